// ### src/bos_descriptor_store.v
// device capability store: holds the descriptor set and streams it out
//
// Functional notes
// - root header: own length, type, 16-bit total length, capability count
// - total length is root size plus every capability size
// - count byte equals number of capability descriptors after root
// - a root-only read and a whole-set read are both answered
// - no request path returns a single capability on its own
// - direct get or set aimed at a capability is refused
// - capabilities always travel inside the store's answer
// - each capability: length, type, subtype at 2, payload from 3
// - subtypes: extension 02H, superspeed 03H, container 04H, plus 0AH
// - only defined subtype codes 01H to 10H are emitted
// - subtype 00H and 11H to FFH never emitted
// - extension, superspeed, plus and optional container always returned
// - extension descriptor always present; link power management supported
// - extension carries subtype at 2 and 4-byte bitmap at 3
// - bitmap one means supported, zero means unsupported
// - bitmap bit 1 link power management driven to one
// - bitmap bit 0 and bits 31:2 return zero
`include "bos_store_map.vh"

module bos_descriptor_store #(
  parameter         HAS_CONTAINER_ID = 1,
  parameter [55:0]  SS_BODY          = 56'h00000000000000,
  parameter [103:0] SSP_BODY         = 104'h00000000000000000000000000,
  parameter [135:0] CID_BODY         = 136'h0000000000000000000000000000000000
) (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        reqValid,
  output wire        reqReady,
  input  wire        reqDir,
  input  wire [7:0]  reqDescType,
  input  wire [7:0]  reqDescIndex,
  input  wire [15:0] reqLength,
  output reg         reqStall,
  output reg         reqDone,
  output wire        outValid,
  input  wire        outReady,
  output wire [7:0]  outData,
  output wire        outLast
);

  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;

  // sizes of the stored image, worked out from what is present
  localparam [15:0] LEN_NO_CID = {8'h00, `ROOT_LEN} + {8'h00, `USB2_EXT_LEN}
                               + {8'h00, `SUPERSPEED_LEN}
                               + {8'h00, `SUPERSPEED_PLUS_LEN};
  localparam [15:0] TOTAL_LEN  = (HAS_CONTAINER_ID != 0)
                               ? LEN_NO_CID + {8'h00, `CONTAINER_ID_LEN}
                               : LEN_NO_CID;
  localparam [7:0]  CAP_COUNT  = (HAS_CONTAINER_ID != 0) ? 8'h04 : 8'h03;
  localparam        IMG_BYTES  = 58;
  localparam        IMG_BITS   = 8 * IMG_BYTES;

  // subtype guard: anything outside the defined range becomes the extension code
  function [7:0] legalSubtype;
    input [7:0] code;
    begin
      if ((code == `CAP_RESERVED_LOW) || (code > `CAP_LAST_DEFINED)) begin
        legalSubtype = `CAP_USB2_EXT;
      end else begin
        legalSubtype = code;
      end
    end
  endfunction

  // three-byte capability header, length byte lowest
  function [23:0] capHeader;
    input [7:0] len;
    input [7:0] code;
    begin
      capHeader = {legalSubtype(code), `DEVCAP_DESC_TYPE, len};
    end
  endfunction

  reg        state_ff;
  reg        nxt_state;
  reg [15:0] sendLen_ff;
  reg [15:0] nxt_sendLen;
  reg [15:0] idx_ff;
  reg [15:0] nxt_idx;

  wire [`EXT_ATTR_WIDTH-1:0] extAttr;
  wire [39:0]                rootSeg;
  wire [55:0]                extSeg;
  wire [79:0]                ssSeg;
  wire [127:0]               sspSeg;
  wire [159:0]               cidSeg;
  wire [IMG_BITS-1:0]        image;
  wire [7:0]                 curByte;
  wire                       isLast;
  wire                       fifoInReady;
  wire                       pushByte;
  wire [8:0]                 fifoOut;
  wire                       acceptReq;
  wire                       isStoreGet;
  wire [15:0]                clipLen;

  // extension bitmap: only the power management bit is set
  assign extAttr = `EXT_ATTR_RESET
                 | ({{(`EXT_ATTR_WIDTH-1){1'b0}}, 1'b1} << `EXT_ATTR_LPM_BIT);

  // root header, total length low byte first
  assign rootSeg = {CAP_COUNT, TOTAL_LEN[15:8], TOTAL_LEN[7:0],
                    `BOS_DESC_TYPE, `ROOT_LEN};

  // mandatory extension capability with its 4-byte bitmap at offset 3
  assign extSeg = {extAttr, capHeader(`USB2_EXT_LEN, `CAP_USB2_EXT)};

  // remaining capabilities returned at every speed
  assign ssSeg  = {SS_BODY, capHeader(`SUPERSPEED_LEN, `CAP_SUPERSPEED)};
  assign sspSeg = {SSP_BODY, capHeader(`SUPERSPEED_PLUS_LEN, `CAP_SUPERSPEED_PLUS)};
  assign cidSeg = {CID_BODY, capHeader(`CONTAINER_ID_LEN, `CAP_CONTAINER_ID)};

  // whole image, byte 0 in the lowest bits; container dropped when absent
  assign image = (HAS_CONTAINER_ID != 0)
               ? {cidSeg, sspSeg, ssSeg, extSeg, rootSeg}
               : {160'h0, sspSeg, ssSeg, extSeg, rootSeg};

  // byte picked by the running index
  assign curByte = image[{idx_ff[5:0], 3'b000} +: 8];
  assign isLast  = (idx_ff == sendLen_ff - 16'h0001);

  // request decode: only a get of the store type is served
  assign reqReady   = (state_ff == ST_IDLE);
  assign acceptReq  = reqValid & reqReady;
  assign isStoreGet = (reqDir == `REQ_DIR_GET)
                    && (reqDescType == `BOS_DESC_TYPE)
                    && (reqDescIndex == 8'h00);

  // answer length is the smaller of asked and stored
  assign clipLen = (reqLength < TOTAL_LEN) ? reqLength : TOTAL_LEN;

  assign pushByte = (state_ff == ST_SEND) & fifoInReady;

  // next state, length and index
  always @* begin
    nxt_state   = state_ff;
    nxt_sendLen = sendLen_ff;
    nxt_idx     = idx_ff;
    case (state_ff)
      ST_IDLE: begin
        if (acceptReq && isStoreGet && (clipLen != 16'h0000)) begin
          nxt_state   = ST_SEND;
          nxt_sendLen = clipLen;
          nxt_idx     = 16'h0000;
        end
      end
      ST_SEND: begin
        if (pushByte) begin
          if (isLast) begin
            nxt_state = ST_IDLE;
            nxt_idx   = 16'h0000;
          end else begin
            nxt_idx = idx_ff + 16'h0001;
          end
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // sequencer registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      sendLen_ff <= 16'h0000;
      idx_ff     <= 16'h0000;
    end else begin
      state_ff   <= nxt_state;
      sendLen_ff <= nxt_sendLen;
      idx_ff     <= nxt_idx;
    end
  end

  // one-cycle answers: stall on refused request, done at the end of data
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqStall <= 1'b0;
      reqDone  <= 1'b0;
    end else begin
      reqStall <= acceptReq & ~isStoreGet;
      reqDone  <= (acceptReq & isStoreGet & (clipLen == 16'h0000))
                | (pushByte & isLast);
    end
  end

  // two-entry buffer so a stalled receiver loses no byte
  byte_skid_fifo #(
    .WIDTH (9),
    .DEPTH (2),
    .AW    (1)
  ) uOutBuf (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (state_ff == ST_SEND),
    .inReady  (fifoInReady),
    .inData   ({isLast, curByte}),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (fifoOut)
  );

  assign outData = fifoOut[7:0];
  assign outLast = fifoOut[8];

endmodule

// ### common/bos_store_map.vh
// constants for the device capability store: codes, lengths, offsets
`ifndef BOS_STORE_MAP_VH
`define BOS_STORE_MAP_VH

// descriptor type codes seen in a get or set descriptor request
`define BOS_DESC_TYPE          8'h0F
`define DEVCAP_DESC_TYPE       8'h10

// capability subtype codes
`define CAP_WIRELESS           8'h01
`define CAP_USB2_EXT           8'h02
`define CAP_SUPERSPEED         8'h03
`define CAP_CONTAINER_ID       8'h04
`define CAP_SUPERSPEED_PLUS    8'h0A
`define CAP_LAST_DEFINED       8'h10
`define CAP_RESERVED_LOW       8'h00

// root header layout
`define ROOT_LEN               8'h05
`define ROOT_OFS_LEN           0
`define ROOT_OFS_TYPE          1
`define ROOT_OFS_TOTAL         2
`define ROOT_OFS_COUNT         4

// common capability header layout
`define CAP_OFS_LEN            0
`define CAP_OFS_TYPE           1
`define CAP_OFS_SUBTYPE        2
`define CAP_OFS_BODY           3

// capability descriptor sizes
`define USB2_EXT_LEN           8'h07
`define SUPERSPEED_LEN         8'h0A
`define SUPERSPEED_PLUS_LEN    8'h10
`define CONTAINER_ID_LEN       8'h14

// usb 2.0 extension attribute bitmap
`define EXT_ATTR_WIDTH         32
`define EXT_ATTR_LPM_BIT       1
`define EXT_ATTR_RESET         32'h00000000

// request direction encoding
`define REQ_DIR_SET            1'b0
`define REQ_DIR_GET            1'b1

`endif

// ### src/byte_skid_fifo.v
// small flip-flop fifo with valid and ready on both sides
module byte_skid_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wrPtr_ff;
  reg [AW-1:0]    rdPtr_ff;
  reg [AW:0]      count_ff;
  wire            doPush;
  wire            doPop;

  // full and empty straight from the occupancy count
  assign inReady  = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData  = mem_ff[rdPtr_ff];
  assign doPush   = inValid & inReady;
  assign doPop    = outValid & outReady;

  // pointer wrap helper
  function [AW-1:0] nextPtr;
    input [AW-1:0] p;
    begin
      if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) begin
        nextPtr = {AW{1'b0}};
      end else begin
        nextPtr = p + {{(AW-1){1'b0}}, 1'b1};
      end
    end
  endfunction

  // pointers and count
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_ff <= nextPtr(wrPtr_ff);
      end
      if (doPop) begin
        rdPtr_ff <= nextPtr(rdPtr_ff);
      end
      if (doPush && !doPop) begin
        count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
      end else if (doPop && !doPush) begin
        count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // storage, written on a push and cleared on a pop so an empty buffer shows no stale flag
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : gSlot
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_ff[g] <= {WIDTH{1'b0}};
        end else if (doPush && (wrPtr_ff == g)) begin
          mem_ff[g] <= inData;
        end else if (doPop && (rdPtr_ff == g)) begin
          mem_ff[g] <= {WIDTH{1'b0}}; // drained slot
        end
      end
    end
  endgenerate

endmodule

// ### verification/bos_descriptor_store_assertions.sv
// port checker for the capability store
module bos_descriptor_store_checker (
  input logic        clk,
  input logic        rst_n,
  input logic        reqValid,
  input logic        reqReady,
  input logic        reqDir,
  input logic [7:0]  reqDescType,
  input logic [7:0]  reqDescIndex,
  input logic [15:0] reqLength,
  input logic        reqStall,
  input logic        reqDone,
  input logic        outValid,
  input logic        outReady,
  input logic [7:0]  outData,
  input logic        outLast
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // request taken, and whether it is a served store read
  wire take = reqValid && reqReady;
  wire good = reqDir && reqDescType == 8'h0F && reqDescIndex == 8'h00;
  wire nz   = reqLength != 16'h0000;
  // served read taken while the buffer is empty
  wire fresh = take && good && nz && !outValid;
  a_refuse_other: assert property (take && !good |=> reqStall)
    else $error("refused request not stalled");
  a_serve_store: assert property (take && good |=> !reqStall)
    else $error("store read stalled");
  a_zero_done: assert property (take && good && !nz |=> reqDone)
    else $error("zero length read not done");
  a_busy_after: assert property (take && good && nz |=> !reqReady)
    else $error("ready while streaming");
  a_first_byte: assert property (fresh |-> ##2 outValid && outData == 8'h05)
    else $error("first byte not root length");
  a_hold_word: assert property (outValid && !outReady
    |=> outValid && $stable(outData) && $stable(outLast))
    else $error("stalled byte changed");
  a_stall_pulse: assert property (reqStall |-> $past(take) && !$past(good))
    else $error("stall without a refused request");
  a_last_valid: assert property (outLast |-> outValid)
    else $error("last without valid");
  // main scenarios
  c_served: cover property (take && good && nz);
  c_refused: cover property (reqStall);
  c_backpressure: cover property (outValid && !outReady);
endmodule

bind bos_descriptor_store bos_descriptor_store_checker i_chk (.clk, .rst_n, .reqValid,
  .reqReady, .reqDir, .reqDescType, .reqDescIndex, .reqLength, .reqStall, .reqDone,
  .outValid, .outReady, .outData, .outLast);

// ### verification/host_reader.sv
// host side reader: takes answer bytes, stalls on demand
module host_reader (
  input  logic       clk,
  input  logic       rst_n,
  input  logic       slow,
  input  logic       outValid,
  input  logic [7:0] outData,
  input  logic       outLast,
  output logic       outReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [0:511];
  int         count;
  int         lastIdx;
  logic [1:0] phase;
  // slow mode: ready one cycle in four
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 0;
      lastIdx <= -1;
      phase <= 2'h0;
      outReady <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      outReady <= !slow || phase == 2'h2;
      if (outValid && outReady) begin
        got[count] <= outData;
        count <= count + 1;
        if (outLast) lastIdx <= count;
      end
    end
  end
endmodule

// ### verification/bos_descriptor_store_test.sv
// self-checking bench for the capability store
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("FAIL %0t got %0h want %0h", $time, a, b); end end
module bos_descriptor_store_test;
  timeunit 1ns;
  timeprecision 1ns;
  // expected image: root, extension, superspeed, plus, container
  localparam logic [463:0] IMG = {40'h050F3A0004, 56'h07100202000000, 24'h0A1003,
    56'h0, 24'h10100A, 104'h0, 24'h141004, 136'h0};
  logic        clk = 1'b0;
  logic        rst_n, reqValid, reqDir, reqStall, reqDone, slow;
  logic        reqReady, outValid, outReady, outLast;
  logic [7:0]  reqDescType, reqDescIndex, outData;
  logic [15:0] reqLength;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc = 0;
  bos_descriptor_store i_bos_descriptor_store (.clk, .rst_n, .reqValid, .reqReady,
    .reqDir, .reqDescType, .reqDescIndex, .reqLength, .reqStall, .reqDone,
    .outValid, .outReady, .outData, .outLast);
  host_reader i_host_reader (.clk, .rst_n, .slow, .outValid, .outData, .outLast,
    .outReady);
  always #25 clk = ~clk;
  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out;
    end
  end
  // one request, then judge the answer and the bytes
  task automatic run(input logic d, input logic [7:0] t, input logic [7:0] x,
                     input logic [15:0] l, input int n, input logic stl);
    int   base;
    int   w;
    logic ended;
    logic stalled;
    base = i_host_reader.count;
    ended = 1'b0;
    stalled = 1'b0;
    do @(negedge clk); while (reqReady !== 1'b1);
    @(posedge clk);
    reqValid <= 1'b1;
    reqDir <= d;
    reqDescType <= t;
    reqDescIndex <= x;
    reqLength <= l;
    @(posedge clk);
    reqValid <= 1'b0;
    for (w = 0; w < 300 && !ended; w++) begin
      @(negedge clk);
      stalled = reqStall;
      ended = reqStall || reqDone;
    end
    for (w = 0; w < 300 && outValid !== 1'b0; w++) @(negedge clk);
    `CHK(ended, 1'b1)
    `CHK(stalled, stl)
    `CHK(i_host_reader.count - base, n)
    for (w = 0; w < n; w++) `CHK(i_host_reader.got[base + w], IMG[463 - 8 * w -: 8])
    if (n > 0) `CHK(i_host_reader.lastIdx, base + n - 1)
  endtask
  task t_header;
    run(1'b1, 8'h0F, 8'h00, 16'h0005, 5, 1'b0);
  endtask
  task t_whole;
    slow <= 1'b1;
    run(1'b1, 8'h0F, 8'h00, 16'h003A, 58, 1'b0);
    slow <= 1'b0;
  endtask
  task t_clip;
    run(1'b1, 8'h0F, 8'h00, 16'hFFFF, 58, 1'b0);
    run(1'b1, 8'h0F, 8'h00, 16'h0001, 1, 1'b0);
  endtask
  task t_partial;
    slow <= 1'b1;
    run(1'b1, 8'h0F, 8'h00, 16'h0017, 23, 1'b0);
    slow <= 1'b0;
  endtask
  task t_zero;
    run(1'b1, 8'h0F, 8'h00, 16'h0000, 0, 1'b0);
  endtask
  task t_refuse;
    run(1'b1, 8'h10, 8'h00, 16'h0007, 0, 1'b1);
    run(1'b0, 8'h10, 8'h00, 16'h0007, 0, 1'b1);
    run(1'b0, 8'h0F, 8'h00, 16'h0005, 0, 1'b1);
    run(1'b1, 8'h0F, 8'h01, 16'h0005, 0, 1'b1);
  endtask
  task close_out;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    reqValid = 1'b0;
    reqDir = 1'b0;
    reqDescType = 8'h00;
    reqDescIndex = 8'h00;
    reqLength = 16'h0000;
    slow = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_header;
    t_whole;
    t_clip;
    t_partial;
    t_zero;
    t_refuse;
    t_header;
    close_out;
  end
endmodule
